// File: common/lp_dram_pkg.sv
// Shared constants and types for the low-power DRAM port block
package lp_dram_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_WIDTH = 16;
  localparam int LANES = DATA_WIDTH / 8;
  localparam int CMD_ADDR_BUS_WIDTH = 10;
  localparam int ADDR_WIDTH = 12;
  localparam int CMD_WIDTH = 4;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 20000;
  localparam int LOCK_TIME_NS = 1000;
  localparam int LOCK_CYC = (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INIT_TIME_US = 200;
  localparam int INIT_CYC = (INIT_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_LAT_CYC = 3;
  localparam int TRAIN_CYC = 16;
  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [CMD_WIDTH-1:0] CMD_WRITE = 4'h1;
  localparam logic [CMD_WIDTH-1:0] CMD_READ = 4'h2;
  localparam logic [CMD_WIDTH-1:0] CMD_TRAIN_READ = 4'hE;
  localparam logic [DATA_WIDTH-1:0] TRAIN_PATTERN = 16'hA55A;
  localparam logic [CMD_ADDR_BUS_WIDTH-1:0] CA_IDLE = 10'h3FF;

  typedef struct packed {
    logic [CMD_WIDTH-1:0] cmd;
    logic [ADDR_WIDTH-1:0] addr;
  } user_cmd_type;

  typedef struct packed {
    logic [DATA_WIDTH-1:0] data;
    logic [LANES-1:0] mask;
  } write_word_type;

  typedef enum logic [7:0] {
    ST_RESET = 8'h01,
    ST_INIT = 8'h02,
    ST_READY = 8'h04,
    ST_CA_FIRST = 8'h08,
    ST_CA_SECOND = 8'h10,
    ST_WDATA = 8'h20,
    ST_RWAIT = 8'h40,
    ST_TRAIN = 8'h80
  } ctrl_state_type;
endpackage

// File: logic/byte_lane_io.sv
// One byte lane of data, mask and strobe pins
`timescale 1ns/1ps
`default_nettype none
module byte_lane_io
  import lp_dram_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic drive_en,
  input wire logic capture,
  input wire logic [7:0] wdata,
  input wire logic wmask,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic dqs_out,
  output logic dqs_oe,
  output logic dm_out,
  output logic [7:0] rdata
);
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
      dm_out <= 1'b0;
      rdata <= 8'h00;
    end
    else
    begin
      dq_out <= drive_en ? wdata : 8'h00;
      dq_oe <= drive_en;
      // Strobe toggles only while the lane drives the write
      dqs_out <= drive_en ? ~dqs_out : 1'b0;
      dqs_oe <= drive_en;
      dm_out <= drive_en & wmask;
      if (capture)
      begin
        rdata <= dq_in;
      end
    end
  end
endmodule // byte_lane_io
`default_nettype wire

// File: logic/lp_dram_init_training_port.sv
// Top of the low-power DRAM controller port: clocks, init, training, command path
//
// Summary of operation
// - User commands become CA, data and mask activity, with ready flow control.
// - A system clock output is derived from the reference clock.
// - Clocking-good rises once the internal clocks are counted stable.
// - Clock-stop high holds the memory clock low; toggling resumes on release.
// - Active-low asynchronous reset returns all state to reset values.
// - One multiplexed CA bus carries command, row and column in phases.
// - One write mask line per byte lane suppresses bytes on writes.
// - One bidirectional strobe per lane, driven on writes; the strobe input is not used, reads are captured after a fixed latency.
// - Init-done pulses exactly one cycle when initialization finishes.
// - A training request starts the read pulse training procedure.
// - Training-active stays high for the whole training run.
// - Training-done rises when the training run completes.
// - Training-error rises when the training run fails.
// - Command-ready is high only when a command can be accepted.
`timescale 1ns/1ps
`default_nettype none
module lp_dram_init_training_port
  import lp_dram_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int LOCK_CYCLES = LOCK_CYC
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clock_stop,
  output logic sys_clock_out,
  output logic clocking_good,
  output logic memory_clock_out,
  output logic memory_clock_enable_out,
  output logic [CMD_ADDR_BUS_WIDTH-1:0] memory_cmd_addr_bus,
  input wire logic [DATA_WIDTH-1:0] memory_data_in,
  output logic [DATA_WIDTH-1:0] memory_data_out,
  output logic [DATA_WIDTH-1:0] memory_data_oe,
  output logic [LANES-1:0] memory_byte_mask,
  input wire logic [LANES-1:0] memory_data_strobe_in,
  output logic [LANES-1:0] memory_data_strobe_out,
  output logic [LANES-1:0] memory_data_strobe_oe,
  output logic memory_select_low,
  input wire logic init_request,
  output logic init_done,
  input wire logic training_request,
  output logic training_active_flag,
  output logic training_complete_flag,
  output logic training_failure_flag,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire user_cmd_type user_cmd,
  input wire write_word_type write_word,
  output logic read_data_valid,
  output logic [DATA_WIDTH-1:0] read_data
);
  // ****************************************
  // Declarations
  // ****************************************
  ctrl_state_type state_reg, state_next;
  logic [15:0] lock_cnt_reg;
  logic [15:0] wait_cnt_reg, wait_cnt_next;
  user_cmd_type cmd_hold_reg, cmd_hold_next;
  write_word_type wword_reg, wword_next;
  logic [CMD_ADDR_BUS_WIDTH-1:0] ca_next;
  logic cs_low_next;
  logic train_pass_reg, train_pass_next;
  logic done_next, fail_next, init_pulse_next;
  logic [DATA_WIDTH-1:0] lane_rdata;
  logic [DATA_WIDTH-1:0] lane_dq_out;
  logic [LANES-1:0] lane_dq_oe;
  logic lock_reached;
  logic lane_drive;
  logic lane_capture;
  logic accept_cmd;
  logic train_start;
  logic unused_strobe;

  function automatic logic [CMD_ADDR_BUS_WIDTH-1:0] ca_first(input user_cmd_type c);
    ca_first = {c.cmd, c.addr[ADDR_WIDTH-1:ADDR_WIDTH-6]};
  endfunction

  function automatic logic [CMD_ADDR_BUS_WIDTH-1:0] ca_second(input user_cmd_type c);
    ca_second = {4'h0, c.addr[5:0]};
  endfunction

  // ****************************************
  // Clocks
  // ****************************************
  assign lock_reached = (lock_cnt_reg >= 16'(LOCK_CYCLES));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_cnt_reg <= 16'h0000;
      clocking_good <= 1'b0;
      sys_clock_out <= 1'b0;
      memory_clock_out <= 1'b0;
    end
    else
    begin
      if (!lock_reached)
      begin
        lock_cnt_reg <= lock_cnt_reg + 16'h0001;
      end
      clocking_good <= lock_reached;
      sys_clock_out <= ~sys_clock_out;
      memory_clock_out <= clock_stop ? 1'b0 : ~memory_clock_out;
    end
  end

  // ****************************************
  // Control decode
  // ****************************************
  assign cmd_ready = (state_reg == ST_READY);
  assign accept_cmd = cmd_ready & cmd_valid;
  // Training requests during a run fall on a non-ready state and are ignored
  assign train_start = (state_reg == ST_READY) & training_request & ~cmd_valid;
  assign lane_drive = (state_reg == ST_WDATA);
  assign lane_capture = (state_reg == ST_RWAIT) && (wait_cnt_reg == 16'h0000);
  assign unused_strobe = ^memory_data_strobe_in;

  // ****************************************
  // State machine
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    wait_cnt_next = wait_cnt_reg;
    cmd_hold_next = cmd_hold_reg;
    wword_next = wword_reg;
    ca_next = CA_IDLE;
    cs_low_next = 1'b1;
    train_pass_next = train_pass_reg;
    done_next = training_complete_flag;
    fail_next = training_failure_flag;
    init_pulse_next = 1'b0;
    unique case (state_reg)
      ST_RESET:
      begin
        if (clocking_good && init_request)
        begin
          state_next = ST_INIT;
          wait_cnt_next = 16'(INIT_CYCLES - 1);
        end
      end
      ST_INIT:
      begin
        if (wait_cnt_reg == 16'h0000)
        begin
          state_next = ST_READY;
          init_pulse_next = 1'b1;
        end
        else
        begin
          wait_cnt_next = wait_cnt_reg - 16'h0001;
        end
      end
      ST_READY:
      begin
        if (accept_cmd)
        begin
          cmd_hold_next = user_cmd;
          wword_next = write_word;
          state_next = ST_CA_FIRST;
        end
        else if (train_start)
        begin
          cmd_hold_next = '{cmd: CMD_TRAIN_READ, addr: '0};
          train_pass_next = 1'b1;
          done_next = 1'b0;
          fail_next = 1'b0;
          wait_cnt_next = 16'(TRAIN_CYC - 1);
          state_next = ST_TRAIN;
        end
      end
      ST_CA_FIRST:
      begin
        ca_next = ca_first(cmd_hold_reg);
        cs_low_next = 1'b0;
        state_next = ST_CA_SECOND;
      end
      ST_CA_SECOND:
      begin
        ca_next = ca_second(cmd_hold_reg);
        cs_low_next = 1'b0;
        if (cmd_hold_reg.cmd == CMD_WRITE)
        begin
          state_next = ST_WDATA;
        end
        else if (cmd_hold_reg.cmd == CMD_READ)
        begin
          wait_cnt_next = 16'(READ_LAT_CYC - 1);
          state_next = ST_RWAIT;
        end
        else
        begin
          state_next = ST_READY;
        end
      end
      ST_WDATA:
      begin
        state_next = ST_READY;
      end
      ST_RWAIT:
      begin
        if (wait_cnt_reg == 16'h0000)
        begin
          state_next = ST_READY;
        end
        else
        begin
          wait_cnt_next = wait_cnt_reg - 16'h0001;
        end
      end
      ST_TRAIN:
      begin
        ca_next = ca_first(cmd_hold_reg);
        cs_low_next = 1'b0;
        // Pins carry the pattern only once the memory is selected
        if (!memory_select_low && (memory_data_in != TRAIN_PATTERN))
        begin
          train_pass_next = 1'b0;
        end
        if (wait_cnt_reg == 16'h0000)
        begin
          state_next = ST_READY;
          done_next = 1'b1;
          fail_next = ~train_pass_next;
        end
        else
        begin
          wait_cnt_next = wait_cnt_reg - 16'h0001;
        end
      end
      default:
      begin
        state_next = ST_RESET;
      end
    endcase
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_RESET;
      wait_cnt_reg <= 16'h0000;
      cmd_hold_reg <= '0;
      wword_reg <= '0;
      train_pass_reg <= 1'b0;
      memory_cmd_addr_bus <= CA_IDLE;
      memory_select_low <= 1'b1;
      memory_clock_enable_out <= 1'b0;
      init_done <= 1'b0;
      training_active_flag <= 1'b0;
      training_complete_flag <= 1'b0;
      training_failure_flag <= 1'b0;
      read_data_valid <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      wait_cnt_reg <= wait_cnt_next;
      cmd_hold_reg <= cmd_hold_next;
      wword_reg <= wword_next;
      train_pass_reg <= train_pass_next;
      memory_cmd_addr_bus <= ca_next;
      memory_select_low <= cs_low_next;
      if (state_reg == ST_INIT)
      begin
        memory_clock_enable_out <= 1'b1;
      end
      init_done <= init_pulse_next;
      training_active_flag <= (state_next == ST_TRAIN);
      training_complete_flag <= done_next;
      training_failure_flag <= fail_next;
      read_data_valid <= lane_capture;
    end
  end

  // ****************************************
  // Byte lanes
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      byte_lane_io u_lane (
        .mclk(mclk),
        .rst_n(rst_n),
        .drive_en(lane_drive),
        .capture(lane_capture),
        .wdata(wword_reg.data[g*8 +: 8]),
        .wmask(wword_reg.mask[g]),
        .dq_in(memory_data_in[g*8 +: 8]),
        .dq_out(lane_dq_out[g*8 +: 8]),
        .dq_oe(lane_dq_oe[g]),
        .dqs_out(memory_data_strobe_out[g]),
        .dqs_oe(memory_data_strobe_oe[g]),
        .dm_out(memory_byte_mask[g]),
        .rdata(lane_rdata[g*8 +: 8])
      );
      assign memory_data_oe[g*8 +: 8] = {8{lane_dq_oe[g]}};
    end
  endgenerate

  assign memory_data_out = lane_dq_out;
  // Read word comes straight from the lane capture flops
  assign read_data = lane_rdata;
endmodule // lp_dram_init_training_port
`default_nettype wire

// File: tb/lp_dram_init_training_port_bench.sv
// Self-checking bench for the DRAM port block
`timescale 1ns/1ps
`default_nettype none
module lp_dram_init_training_port_bench;
  import lp_dram_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, clock_stop = 1'b0, init_request = 1'b0, training_request = 1'b0;
  logic cmd_valid = 1'b0, train_bad = 1'b0, act_prev = 1'b0;
  user_cmd_type user_cmd = '0;
  write_word_type write_word = '0;
  logic [DATA_WIDTH-1:0] rd_word = '0, memory_data_in, memory_data_out, memory_data_oe, read_data;
  logic [LANES-1:0] strobe_in, strobe_out, strobe_oe, memory_byte_mask;
  logic [CMD_ADDR_BUS_WIDTH-1:0] memory_cmd_addr_bus;
  logic memory_select_low, init_done, training_active_flag, training_complete_flag, training_failure_flag;
  logic cmd_ready, read_data_valid, clocking_good, cke;
  logic [17:0] exp_q[$], ca_q[$];
  int num_errors = 0, checks = 0, cyc = 0, n;
  always #10 mclk = ~mclk;
  lp_dram_init_training_port #(.INIT_CYCLES(20), .LOCK_CYCLES(4)) i_dut (.mclk, .rst_n, .clock_stop,
    .sys_clock_out(), .clocking_good, .memory_clock_out(), .memory_clock_enable_out(cke), .memory_cmd_addr_bus,
    .memory_data_in, .memory_data_out, .memory_data_oe, .memory_byte_mask, .memory_data_strobe_in(strobe_in),
    .memory_data_strobe_out(strobe_out), .memory_data_strobe_oe(strobe_oe), .memory_select_low, .init_request,
    .init_done,
    .training_request, .training_active_flag, .training_complete_flag, .training_failure_flag, .cmd_valid,
    .cmd_ready, .user_cmd, .write_word, .read_data_valid, .read_data);
  lp_dram_mem_model i_mem (.mclk, .memory_select_low, .train_bad, .rd_word, .memory_data_in,
    .memory_data_strobe_in(strobe_in));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [17:0] pop(ref logic [17:0] q[$]);
    return q.size() > 0 ? q.pop_front() : 'x;
  endfunction
  // Bounded wait, sampled at falling edges
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 200)
      chk(18'h0, 18'h1);
  endtask
  task automatic cmd(input logic [3:0] c);
    logic [11:0] a;
    a = 12'($urandom);
    wait_for(cmd_ready, 1'b1);
    rd_word = 16'($urandom);
    user_cmd = '{c, a};
    write_word = '{16'($urandom), 2'($urandom)};
    cmd_valid = 1'b1;
    ca_q.push_back({8'h0, c, a[11:6]});
    ca_q.push_back({12'h0, a[5:0]});
    if (c == CMD_WRITE) exp_q.push_back({write_word.data, write_word.mask});
    if (c == CMD_READ) exp_q.push_back({rd_word, 2'b00});
    @(negedge mclk);
    cmd_valid = 1'b0;
  endtask
  task automatic train(input logic bad);
    wait_for(cmd_ready, 1'b1);
    train_bad = bad;
    training_request = 1'b1;
    exp_q.push_back({16'h0, 1'b1, bad});
    wait_for(training_active_flag, 1'b1);
    training_request = 1'b0;
    repeat (3) @(negedge mclk);
    training_request = 1'b1;
    repeat (3) @(negedge mclk);
    training_request = 1'b0;
    wait_for(training_active_flag, 1'b0);
  endtask
  task automatic do_init;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    cmd_valid = 1'b1;
    wait_for(clocking_good, 1'b1);
    init_request = 1'b1;
    wait_for(init_done, 1'b1);
    init_request = 1'b0;
    cmd_valid = 1'b0;
    @(negedge mclk);
  endtask
  // Result watcher: oldest note against each result as it shows
  always @(negedge mclk)
  begin
    if (rst_n)
    begin
      if (|memory_data_oe) chk({memory_data_out, memory_byte_mask}, pop(exp_q));
      if (|memory_data_oe) chk(18'(strobe_oe), 18'({LANES{1'b1}}));
      if (read_data_valid) chk({read_data, 2'b00}, pop(exp_q));
      if (!memory_select_low && ca_q.size() > 0) chk(18'(memory_cmd_addr_bus), pop(ca_q));
      if (act_prev && !training_active_flag) chk({16'h0, training_complete_flag, training_failure_flag},
        pop(exp_q));
      if (init_done) chk(18'({cmd_ready, cke}), 18'h3);
    end
    act_prev = training_active_flag;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      num_errors++;
      end_sim;
    end
  end
  initial
  begin
    void'($urandom(6125));
    do_init;
    for (int i = 0; i < 12; i++)
      cmd(i % 3 == 0 ? CMD_READ : i % 3 == 1 ? CMD_WRITE : 4'($urandom));
    train(1'b0);
    train(1'b1);
    train(1'b0);
    clock_stop = 1'b1;
    repeat (4) @(negedge mclk);
    clock_stop = 1'b0;
    training_request = 1'b1;
    wait_for(training_active_flag, 1'b1);
    repeat (3) @(negedge mclk);
    rst_n = 1'b0;
    training_request = 1'b0;
    #1;
    chk(18'({training_active_flag, memory_select_low, memory_cmd_addr_bus}), 18'({2'b01, CA_IDLE}));
    exp_q.delete();
    ca_q.delete();
    do_init;
    cmd(CMD_READ);
    cmd(CMD_WRITE);
    repeat (10) @(negedge mclk);
    end_sim;
  end
endmodule // lp_dram_init_training_port_bench
`default_nettype wire

// File: tb/lp_dram_mem_model.sv
// Behavioural memory device at the pin side
`timescale 1ns/1ps
`default_nettype none
module lp_dram_mem_model
  import lp_dram_pkg::*;
(
  input wire logic mclk,
  input wire logic memory_select_low,
  input wire logic train_bad,
  input wire logic [DATA_WIDTH-1:0] rd_word,
  output logic [DATA_WIDTH-1:0] memory_data_in,
  output logic [LANES-1:0] memory_data_strobe_in
);
  logic [2:0] hold_reg = 3'h0;
  logic alt_reg = 1'b0;
  // Pattern while selected, read word for four cycles after, churn otherwise
  assign memory_data_in = !memory_select_low ? TRAIN_PATTERN ^ {DATA_WIDTH{train_bad}} :
    (hold_reg != 3'h0) ? rd_word : rd_word ^ {DATA_WIDTH{alt_reg}};
  assign memory_data_strobe_in = (hold_reg != 3'h0) ? {LANES{alt_reg}} : {LANES{1'b0}};
  always @(posedge mclk)
  begin
    alt_reg <= !alt_reg;
    if (!memory_select_low)
      hold_reg <= 3'h4;
    else if (hold_reg != 3'h0)
      hold_reg <= hold_reg - 3'h1;
  end
endmodule // lp_dram_mem_model
`default_nettype wire

// File: tb/lp_dram_port_monitor.sv
// Checker for the DRAM port block
`timescale 1ns/1ps
`default_nettype none
module lp_dram_port_monitor
  import lp_dram_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clock_stop,
  input wire logic sys_clock_out,
  input wire logic memory_clock_out,
  input wire logic memory_select_low,
  input wire logic [DATA_WIDTH-1:0] memory_data_oe,
  input wire logic [LANES-1:0] memory_byte_mask,
  input wire logic init_done,
  input wire logic training_active_flag,
  input wire logic training_complete_flag,
  input wire logic cmd_valid,
  input wire logic cmd_ready
);
  logic init_seen_reg;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      init_seen_reg <= 1'b0;
    else if (init_done)
      init_seen_reg <= 1'b1;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  clk_stop_a: assert property (clock_stop |=> !memory_clock_out)
    else $error("memory clock ran while stopped");
  sys_clk_a: assert property (1'b1 |=> sys_clock_out != $past(sys_clock_out))
    else $error("system clock stalled");
  init_pulse_a: assert property (init_done |=> !init_done)
    else $error("init done longer than one cycle");
  init_gate_a: assert property (!init_seen_reg && !init_done |-> !cmd_ready)
    else $error("ready before init");
  cmd_take_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready ##1 !memory_select_low [*2])
    else $error("command acceptance wrong");
  mask_idle_a: assert property (memory_data_oe == '0 |-> memory_byte_mask == '0)
    else $error("mask outside write");
  train_len_a: assert property ($rose(training_active_flag) |-> training_active_flag [*8] ##1
    training_active_flag [*8] ##1 (!training_active_flag && training_complete_flag))
    else $error("training run length wrong");
  train_busy_a: assert property (training_active_flag |-> !cmd_ready)
    else $error("ready during training");
  cover property (init_done);
  cover property (cmd_valid && cmd_ready);
  cover property ($fell(training_active_flag));
endmodule // lp_dram_port_monitor
bind lp_dram_init_training_port lp_dram_port_monitor i_mon (.mclk, .rst_n, .clock_stop, .sys_clock_out,
  .memory_clock_out, .memory_select_low, .memory_data_oe, .memory_byte_mask, .init_done,
  .training_active_flag, .training_complete_flag, .cmd_valid, .cmd_ready);
`default_nettype wire
